// *** rtl/amg_regs.svh ***
// Register offsets, field positions and encodings of the line gating block.
`ifndef AMG_REGS_SVH
`define AMG_REGS_SVH

// Number of lines per emulated unit and the largest number of units.
`define AMG_LINES_PER_UNIT 8
`define AMG_MAX_UNITS      6
`define AMG_MAX_LINES      48

// Byte address of the first selectable base and the 32-byte block step.
`define AMG_BASE_ORIGIN    18'h3E000
`define AMG_BLOCK_BYTES    18'h00020

// Maintenance function encodings of the two-bit select field.
`define AMG_FCN_NORMAL     2'h0
`define AMG_FCN_ECHO       2'h1
`define AMG_FCN_LOCAL      2'h2
`define AMG_FCN_REMOTE     2'h3

// Field positions inside a line control word.
`define AMG_BIT_TX_EN      0
`define AMG_BIT_RX_EN      2
`define AMG_BIT_FCN_LO     6
`define AMG_BIT_FCN_HI     7
`define AMG_BIT_DTR        9
`define AMG_BIT_RTS        12
`define AMG_BIT_CTS_IND    13
`define AMG_BIT_CAR_IND    14

// Reset value of a line control word.
`define AMG_LINE_RESET     16'h0000

`endif

// *** rtl/amg_pkg.sv ***
// Types shared by the line gating block.
package amg_pkg;

  // Programmed per-line control bits.
  typedef struct packed {
    logic [1:0] maint_function_select;
    logic       dtr;
    logic       rts;
    logic       rx_en;
    logic       tx_en;
  } amg_line_ctrl_t;

  // Modem inputs of one line after synchronisation.
  typedef struct packed {
    logic cd;
    logic cts;
    logic rxd;
  } amg_line_in_t;

endpackage

// *** rtl/amg_line_gate.sv ***
// Per-line gating of receiver, transmitter and modem outputs by mode.
`timescale 1ns/1ps
`include "amg_regs.svh"

module amg_line_gate (
  input  wire logic                    clock_i,
  input  wire logic                    nrst_i,
  input  wire amg_pkg::amg_line_ctrl_t ctrl_i,
  input  wire amg_pkg::amg_line_in_t   pin_i,
  input  wire logic                    txd_uart_i,
  output logic                         txd_o,
  output logic                         rxd_o,
  output logic                         dtr_o,
  output logic                         rts_o,
  output logic                         rx_run_o,
  output logic                         tx_run_o,
  output logic                         carrier_indication_o,
  output logic                         cts_ind_o
);

  // Mode decode.
  wire logic is_local  =
    (ctrl_i.maint_function_select == `AMG_FCN_LOCAL);
  wire logic is_echo   = (ctrl_i.maint_function_select == `AMG_FCN_ECHO);
  wire logic is_remote = (ctrl_i.maint_function_select == `AMG_FCN_REMOTE);

  // In local loop the indications come from the programmed bits.
  wire logic car_ind   = is_local ? ctrl_i.dtr : pin_i.cd;
  wire logic cts_ind   = is_local ? ctrl_i.rts : pin_i.cts;

  // Receiver and transmitter run only with their indication on.
  wire logic rx_run    = ctrl_i.rx_en & car_ind;
  wire logic tx_run    = (ctrl_i.tx_en | is_remote) & cts_ind;

  // Echo and remote loop resend line data; local loop holds the line mark.
  wire logic next_txd  = is_local ? 1'b1 :
                         (is_echo | is_remote) ?
                         (pin_i.rxd | ~tx_run) :
                         (txd_uart_i | ~tx_run);

  // The receiver sees the transmitter in local loop, idle in remote loop.
  wire logic next_rxd  = is_local ? txd_uart_i :
                         is_remote ? 1'b1 :
                         (pin_i.rxd | ~rx_run);

  // Registered outputs; line idles at mark and modem outputs off at reset.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txd_o                <= 1'b1;
      rxd_o                <= 1'b1;
      dtr_o                <= 1'b0;
      rts_o                <= 1'b0;
      rx_run_o             <= 1'b0;
      tx_run_o             <= 1'b0;
      carrier_indication_o <= 1'b0;
      cts_ind_o            <= 1'b0;
    end else begin
      txd_o                <= next_txd;
      rxd_o                <= next_rxd;
      dtr_o                <= ctrl_i.dtr & ~is_local;
      rts_o                <= ctrl_i.rts & ~is_local;
      rx_run_o             <= rx_run;
      tx_run_o             <= tx_run;
      carrier_indication_o <= car_ind;
      cts_ind_o            <= cts_ind;
    end
  end

endmodule

// *** rtl/amg_mux_top.sv ***
// Top of the line gating block: register slave, pin sync, line gates.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "amg_regs.svh"

module amg_mux_top (
  input  wire logic                       clock_i,
  input  wire logic                       nrst_i,
  input  wire logic [17:0]                bus_addr_i,
  input  wire logic [15:0]                bus_wdata_i,
  input  wire logic                       bus_write_i,
  input  wire logic                       bus_read_i,
  output logic      [15:0]                bus_rdata_o,
  output logic                            bus_ack_o,
  input  wire logic [1:0]                 panel_count_switch_i,
  input  wire logic [3:0]                 base_select_i,
  input  wire logic [`AMG_MAX_LINES-1:0]  line_cd_i,
  input  wire logic [`AMG_MAX_LINES-1:0]  line_cts_i,
  input  wire logic [`AMG_MAX_LINES-1:0]  line_rxd_i,
  input  wire logic [`AMG_MAX_LINES-1:0]  txd_uart_i,
  output logic      [`AMG_MAX_LINES-1:0]  line_txd_o,
  output logic      [`AMG_MAX_LINES-1:0]  line_dtr_o,
  output logic      [`AMG_MAX_LINES-1:0]  line_rts_o,
  output logic      [`AMG_MAX_LINES-1:0]  rx_data_o,
  output logic      [`AMG_MAX_LINES-1:0]  rx_run_o,
  output logic      [`AMG_MAX_LINES-1:0]  tx_run_o
);

  // Two-stage synchronisers for every pin input; stage one is read only
  // by stage two.
  logic [`AMG_MAX_LINES-1:0] cd_s1;    // First stage, carrier.
  logic [`AMG_MAX_LINES-1:0] cd_s2;    // Second stage, carrier.
  logic [`AMG_MAX_LINES-1:0] cts_s1;   // First stage, clear-to-send.
  logic [`AMG_MAX_LINES-1:0] cts_s2;   // Second stage, clear-to-send.
  logic [`AMG_MAX_LINES-1:0] rxd_s1;   // First stage, line data.
  logic [`AMG_MAX_LINES-1:0] rxd_s2;   // Second stage, line data.
  logic [5:0]                sw_s1;    // First stage, switches.
  logic [5:0]                sw_s2;    // Second stage, switches.

  // Synchronise pins; data idles at mark so reset to one.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cd_s1  <= '0;
      cd_s2  <= '0;
      cts_s1 <= '0;
      cts_s2 <= '0;
      rxd_s1 <= '1;
      rxd_s2 <= '1;
      sw_s1  <= 6'h00;
      sw_s2  <= 6'h00;
    end else begin
      cd_s1  <= line_cd_i;
      cd_s2  <= cd_s1;
      cts_s1 <= line_cts_i;
      cts_s2 <= cts_s1;
      rxd_s1 <= line_rxd_i;
      rxd_s2 <= rxd_s1;
      sw_s1  <= {panel_count_switch_i, base_select_i};
      sw_s2  <= sw_s1;
    end
  end

  // Switch settings after synchronisation.
  wire logic [1:0] panel_sw = sw_s2[5:4];
  wire logic [3:0] base_sw  = sw_s2[3:0];

  // Unit count is twice the panel count; the unused code counts as two.
  wire logic [2:0] panels = 3'h1 + {2'h0, panel_sw[0]} + {2'h0, panel_sw[1]};
  wire logic [3:0] units  = {panels, 1'b0};

  // Base sits on a 32-byte step, so its low five bits are zero.
  wire logic [17:0] base_addr = `AMG_BASE_ORIGIN +
                                {9'h000, base_sw, 5'h00};

  // Offset from base; a borrow means the address is below the base.
  wire logic [18:0] offs_full = {1'b0, bus_addr_i} - {1'b0, base_addr};
  wire logic        below     = offs_full[18];
  wire logic [17:0] offs      = offs_full[17:0];

  // Hit when the block number is below the unit count.
  wire logic        block_hit = ~below &&
                                (offs[17:5] < {9'h000, units});
  wire logic        upper_reg = offs[4];
  wire logic [5:0]  line_idx  = {offs[7:5], offs[3:1]};
  wire logic        line_hit  = block_hit && !upper_reg;
  wire logic        wr_line   = bus_write_i && line_hit;
  wire logic        any_acc   = bus_write_i || bus_read_i;

  // Programmed control of every line.
  amg_pkg::amg_line_ctrl_t ctrl_q [`AMG_MAX_LINES];

  // Control decoded from the write data.
  amg_pkg::amg_line_ctrl_t wr_ctrl;
  assign wr_ctrl.maint_function_select =
           bus_wdata_i[`AMG_BIT_FCN_HI:`AMG_BIT_FCN_LO];
  assign wr_ctrl.dtr   = bus_wdata_i[`AMG_BIT_DTR];
  assign wr_ctrl.rts   = bus_wdata_i[`AMG_BIT_RTS];
  assign wr_ctrl.rx_en = bus_wdata_i[`AMG_BIT_RX_EN];
  assign wr_ctrl.tx_en = bus_wdata_i[`AMG_BIT_TX_EN];

  // Line control registers; only hits on a line word store data.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < `AMG_MAX_LINES; i++) begin
        ctrl_q[i] <= '0;
      end
    end else if (wr_line) begin
      ctrl_q[line_idx] <= wr_ctrl;
    end
  end

  // Gate outputs of every line.
  logic [`AMG_MAX_LINES-1:0] car_ind;  // Effective carrier per line.
  logic [`AMG_MAX_LINES-1:0] cts_ind;  // Effective clear-to-send per line.

  // One gate per line.
  for (genvar g = 0; g < `AMG_MAX_LINES; g++) begin : gen_line
    amg_line_gate u_gate (
      .clock_i              (clock_i),
      .nrst_i               (nrst_i),
      .ctrl_i               (ctrl_q[g]),
      .pin_i                ({cd_s2[g], cts_s2[g], rxd_s2[g]}),
      .txd_uart_i           (txd_uart_i[g]),
      .txd_o                (line_txd_o[g]),
      .rxd_o                (rx_data_o[g]),
      .dtr_o                (line_dtr_o[g]),
      .rts_o                (line_rts_o[g]),
      .rx_run_o             (rx_run_o[g]),
      .tx_run_o             (tx_run_o[g]),
      .carrier_indication_o (car_ind[g]),
      .cts_ind_o            (cts_ind[g])
    );
  end

  // Read word of the addressed line, with its live indications.
  // Off a hit the index can pass the last line; next_rdata masks it.
  amg_pkg::amg_line_ctrl_t rd_ctrl;
  assign rd_ctrl = ctrl_q[line_idx];
  logic [15:0] line_word;
  always_comb begin
    line_word = `AMG_LINE_RESET;
    line_word[`AMG_BIT_FCN_HI:`AMG_BIT_FCN_LO] = rd_ctrl.maint_function_select;
    line_word[`AMG_BIT_DTR]     = rd_ctrl.dtr;
    line_word[`AMG_BIT_RTS]     = rd_ctrl.rts;
    line_word[`AMG_BIT_RX_EN]   = rd_ctrl.rx_en;
    line_word[`AMG_BIT_TX_EN]   = rd_ctrl.tx_en;
    line_word[`AMG_BIT_CAR_IND] = car_ind[line_idx];
    line_word[`AMG_BIT_CTS_IND] = cts_ind[line_idx];
  end

  // Upper words of a block acknowledge and read zero.
  wire logic [15:0] next_rdata = (bus_read_i && line_hit) ? line_word :
                                 16'h0000;

  // Acknowledge one cycle after a strobe, only inside configured blocks,
  // so a probe past the last unit sees silence.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_rdata_o <= 16'h0000;
      bus_ack_o   <= 1'b0;
    end else begin
      bus_rdata_o <= next_rdata;
      bus_ack_o   <= any_acc && block_hit;
    end
  end

  // Checks on line zero and the bus answer.
  local_dtr_off_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ctrl_q[0].maint_function_select == `AMG_FCN_LOCAL) |=> !line_dtr_o[0])
    else $error("DTR pin on in local loopback");
  local_rts_off_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ctrl_q[0].maint_function_select == `AMG_FCN_LOCAL) |=> !line_rts_o[0])
    else $error("RTS pin on in local loopback");
  local_car_follow_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ctrl_q[0].maint_function_select == `AMG_FCN_LOCAL)
    |=> car_ind[0] == $past(ctrl_q[0].dtr))
    else $error("Carrier does not follow DTR");
  local_cts_follow_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ctrl_q[0].maint_function_select == `AMG_FCN_LOCAL)
    |=> cts_ind[0] == $past(ctrl_q[0].rts))
    else $error("Clear-to-send does not follow RTS");
  rx_carrier_gate_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ctrl_q[0].maint_function_select != `AMG_FCN_LOCAL) && !cd_s2[0]
    |=> !rx_run_o[0])
    else $error("Receiver runs without carrier");
  tx_cts_gate_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ctrl_q[0].maint_function_select != `AMG_FCN_LOCAL) && !cts_s2[0]
    |=> !tx_run_o[0])
    else $error("Transmitter runs without clear-to-send");
  local_loop_data_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (ctrl_q[0].maint_function_select == `AMG_FCN_LOCAL)
    |=> line_txd_o[0] && (rx_data_o[0] == $past(txd_uart_i[0])))
    else $error("Local loopback data path wrong");
  no_ack_outside_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    any_acc && !block_hit |=> !bus_ack_o)
    else $error("Acknowledge outside configured blocks");
  last_unit_ack_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    any_acc && !below && (offs[17:5] == {9'h000, units} - 13'h0001)
    |=> bus_ack_o)
    else $error("Last unit block not acknowledged");
  // Read data must fall back to zero outside the answer cycle, or a
  // stale word could be taken for a fresh one by a careless host.
  rdata_idle_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !bus_read_i |=> bus_rdata_o == 16'h0000)
    else $error("Read data not zero outside a read");
  ack_needs_strobe_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !any_acc |=> !bus_ack_o)
    else $error("Acknowledge without a strobe");

endmodule

// *** rtl/amg_pkg_note_unused.sv ***
// Intentionally empty compilation unit kept out of the build order.

// *** testbench/amg_modem_model.sv ***
// Modem model standing on the line side of every serial line.
`timescale 1ns/1ps
`include "amg_regs.svh"

module amg_modem_model (
  input  wire logic                      clock_i,
  input  wire logic                      nrst_i,
  input  wire logic [`AMG_MAX_LINES-1:0] cd_on_i,
  input  wire logic [`AMG_MAX_LINES-1:0] cts_on_i,
  input  wire logic [`AMG_MAX_LINES-1:0] rxd_drv_i,
  output logic      [`AMG_MAX_LINES-1:0] cd_o,
  output logic      [`AMG_MAX_LINES-1:0] cts_o,
  output logic      [`AMG_MAX_LINES-1:0] rxd_o
);
  // Carrier and line data are presented exactly as the bench commands.
  assign cd_o  = cd_on_i;
  assign rxd_o = rxd_drv_i;

  // Clear-to-send lags its command by a cycle, as a real set is never instant.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cts_o <= '0;
    end else begin
      cts_o <= cts_on_i;
    end
  end
endmodule

// *** testbench/amg_mux_top_tb.sv ***
// Self-checking bench for the line gating block with its modem model.
`timescale 1ns/1ps
`include "amg_regs.svh"

module amg_mux_top_tb;
  localparam int NL = `AMG_MAX_LINES;
  logic          clock = 1'b0;    // System clock.
  logic          nrst_i;          // Active low reset.
  logic [17:0]   addr;            // Bus address.
  logic [15:0]   wdata, rdata;    // Bus data.
  logic          wr_s, rd_s, ack; // Strobes and acknowledge.
  logic [1:0]    panels;          // Panel count switch.
  logic [3:0]    bsel;            // Base select switch.
  logic [NL-1:0] cd_on, cts_on, rxd_drv, uart_tx, cd, cts, rxd;
  logic [NL-1:0] txd, dtr, rts, rxdat, rxrun, txrun;
  logic [5:0]    e;               // Expected line outputs.
  int            bad_count = 0, n_checks = 0, cycles = 0;
  logic [1:0]    pc [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
  int            un [4] = '{2, 4, 4, 6};

  always #5 clock = ~clock;

  amg_modem_model i_modem (.clock_i(clock), .nrst_i(nrst_i),
    .cd_on_i(cd_on), .cts_on_i(cts_on), .rxd_drv_i(rxd_drv),
    .cd_o(cd), .cts_o(cts), .rxd_o(rxd));

  amg_mux_top i_dut (.clock_i(clock), .nrst_i(nrst_i), .bus_addr_i(addr),
    .bus_wdata_i(wdata), .bus_write_i(wr_s), .bus_read_i(rd_s),
    .bus_rdata_o(rdata), .bus_ack_o(ack), .panel_count_switch_i(panels),
    .base_select_i(bsel), .line_cd_i(cd), .line_cts_i(cts),
    .line_rxd_i(rxd), .txd_uart_i(uart_tx), .line_txd_o(txd),
    .line_dtr_o(dtr), .line_rts_o(rts), .rx_data_o(rxdat),
    .rx_run_o(rxrun), .tx_run_o(txrun));

  // Word compare; unknowns never count as a match.
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
               got, exp);
    end
  endtask

  // Line compare packs dtr, rts, txd, rx data, rx run and tx run.
  task automatic chk_line(input int n, input logic [5:0] exp);
    cmp({10'h0, dtr[n], rts[n], txd[n], rxdat[n], rxrun[n], txrun[n]},
        {10'h0, exp}, "line outputs");
  endtask

  // One bus cycle; the acknowledge is checked in the cycle after it.
  task automatic access(input logic wr, input logic [17:0] a,
                        input logic [15:0] d, input logic exp_ack);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_s  <= wr;
    rd_s  <= !wr;
    @(posedge clock);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    #1 cmp({15'h0, ack}, {15'h0, exp_ack}, "ack");
  endtask

  // A read also compares the data standing beside the acknowledge.
  task automatic rd(input logic [17:0] a, input logic [15:0] exp,
                    input logic exp_ack);
    access(1'b0, a, 16'h0000, exp_ack);
    cmp(rdata, exp, "read data");
  endtask

  // Pins need two sync stages plus the model's lag, so wait generously.
  task automatic settle;
    repeat (6) @(posedge clock);
    #1;
  endtask

  function automatic logic [17:0] base;
    return `AMG_BASE_ORIGIN + 18'(bsel) * `AMG_BLOCK_BYTES;
  endfunction

  function automatic logic [17:0] la(input int n);
    return base() + 18'(n / 8) * `AMG_BLOCK_BYTES + 18'((n % 8) * 2);
  endfunction

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hang is cut short well above the fewer than 200 cycles the run needs.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      tally_and_finish();
    end
  end

  initial begin
    nrst_i = 1'b0;
    addr = 18'h00000;
    wdata = 16'h0000;
    wr_s = 1'b0;
    rd_s = 1'b0;
    panels = 2'h0;
    bsel = 4'h0;
    cd_on = '0;
    cts_on = '0;
    rxd_drv = '1;
    uart_tx = '1;
    repeat (3) @(posedge clock);
    nrst_i <= 1'b1;
    settle();
    chk_line(0, 6'b001100);
    rd(la(0), 16'h0000, 1'b1);
    $display("Test reset state done");
    // Normal, echo and remote modes all wait on carrier and clear-to-send.
    // Line zero is used so the design's own line checks see real traffic.
    for (int m = 0; m < 4; m++) begin
      if (m == 2) continue;
      cd_on[0] <= 1'b0;
      cts_on[0] <= 1'b0;
      access(1'b1, la(0), 16'h1205 | 16'(m << 6), 1'b1);
      settle();
      chk_line(0, 6'b111100);
      cd_on[0] <= 1'b1;
      cts_on[0] <= 1'b1;
      settle();
      chk_line(0, 6'b111111);
      rd(la(0), 16'h7205 | 16'(m << 6), 1'b1);
      rxd_drv[0] <= 1'b0;
      settle();
      e = (m == 0) ? 6'b111011 : (m == 1) ? 6'b110011 : 6'b110111;
      chk_line(0, e);
      rxd_drv[0] <= 1'b1;
    end
    $display("Test modem gating done");
    // Local loopback: line pins are ignored, stale pin data must not leak.
    // Line zero again, with its modem pins dropped first.
    cd_on[0] <= 1'b0;
    cts_on[0] <= 1'b0;
    rxd_drv[0] <= 1'b0;
    uart_tx[0] <= 1'b0;
    access(1'b1, la(0), 16'h1285, 1'b1);
    settle();
    chk_line(0, 6'b001011);
    rd(la(0), 16'h7285, 1'b1);
    uart_tx[0] <= 1'b1;
    cd_on[0] <= 1'b1;
    cts_on[0] <= 1'b1;
    access(1'b1, la(0), 16'h0285, 1'b1);
    settle();
    chk_line(0, 6'b001110);
    rd(la(0), 16'h4285, 1'b1);
    access(1'b1, la(0), 16'h1085, 1'b1);
    settle();
    chk_line(0, 6'b001101);
    rd(la(0), 16'h3085, 1'b1);
    $display("Test local loopback done");
    // Every panel setting, last block word answers and the next does not.
    for (int i = 0; i < 4; i++) begin
      panels <= pc[i];
      settle();
      rd(base() + 18'(un[i] * 32 - 2), 16'h0000, 1'b1);
      rd(base() + 18'(un[i] * 32), 16'h0000, 1'b0);
      access(1'b1, base() + 18'(un[i] * 32), 16'hFFFF, 1'b0);
      rd(base() - 18'h00002, 16'h0000, 1'b0);
    end
    access(1'b1, la(40), 16'h0200, 1'b1);
    settle();
    chk_line(40, 6'b101100);
    bsel <= 4'h1;
    settle();
    rd(`AMG_BASE_ORIGIN, 16'h0000, 1'b0);
    rd(la(40), 16'h0200, 1'b1);
    rd(base() + 18'h000BE, 16'h0000, 1'b1);
    $display("Test address decode done");
    tally_and_finish();
  end
endmodule
